// File: rtl/sms_core.sv
/*
 * sms_core: byte-wide full-duplex serial shift engine, master or slave.
 * Assumes pins and the slave select come from outside the clock domain
 * and pass the three-stage filter here; control bits are plain levels
 * held by software; one bus clock drives everything.
 */
`timescale 1ns/100ps
module sms_core #(
    parameter int unsigned BUF_DEPTH = sms_pkg::BUF_DEPTH
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control levels
    input  wire logic       moduleEnable,
    input  wire logic       masterSelect,
    input  wire logic       clockPhaseSel,
    input  wire logic       clockPolaritySel,
    input  wire logic       modeFaultEnable,
    input  wire logic       rateSelectHi,
    input  wire logic       rateSelectLo,
    // transmit side
    input  wire logic       txWrite,
    input  wire logic [7:0] txData,
    output wire logic       txEmptyFlag,
    // receive side and flags
    input  wire logic       rxRead,
    input  wire logic       overrunClear,
    input  wire logic       faultClear,
    output wire logic [7:0] rxData,
    output wire logic       rxFullFlag,
    output wire logic       overrunFlag,
    output wire logic       modeFaultFlag,
    output wire logic       moduleActive,
    // serial clock pin
    input  wire logic       serialClockPinIn,
    output wire logic       serialClockPinOut,
    output wire logic       serialClockPinOe,
    // data pins
    input  wire logic       mosiIn,
    output wire logic       mosiOut,
    output wire logic       mosiOe,
    input  wire logic       misoIn,
    output wire logic       misoOut,
    output wire logic       misoOe,
    // slave select, active low
    input  wire logic       slaveSelN
);
    if (BUF_DEPTH != 2) begin : g_chk
        $error("sms_core: transmit buffer must hold two bytes");
    end

    // ---- pin filter ----
    logic [3:0] pinRaw;   // {sck, mosi, miso, select_n}
    logic [3:0] sync1_r;  // first stage, read by sync2 only
    logic [3:0] sync2_r;  // second stage
    logic [3:0] sync3_r;  // third stage
    logic [3:0] pinF_r;   // accepted pin levels
    logic [3:0] pinP_r;   // accepted levels one cycle back

    assign pinRaw = {serialClockPinIn, mosiIn, misoIn, slaveSelN};

    // three-stage synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= sms_pkg::PIN_RST;
            sync2_r <= sms_pkg::PIN_RST;
            sync3_r <= sms_pkg::PIN_RST;
        end else begin
            sync1_r <= pinRaw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinF_r <= sms_pkg::PIN_RST;
            pinP_r <= sms_pkg::PIN_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sync2_r[i] == sync3_r[i]) pinF_r[i] <= sync3_r[i];
            end
            pinP_r <= pinF_r;
        end
    end

    logic sckF;      // filtered serial clock
    logic mosiF;     // filtered mosi
    logic misoF;     // filtered miso
    logic ssF;       // filtered select, high = deselected
    logic sckEdge;   // serial clock changed
    logic ssFall;    // select just went low
    assign sckF    = pinF_r[3];
    assign mosiF   = pinF_r[2];
    assign misoF   = pinF_r[1];
    assign ssF     = pinF_r[0];
    assign sckEdge = pinF_r[3] != pinP_r[3];
    assign ssFall  = pinP_r[0] && !pinF_r[0];

    // ---- enable and mode fault ----
    logic faultOff_r;  // cleared enable after master fault
    logic enEff;       // module really enabled
    logic master;      // master and enabled
    logic clock_phase_sel;        // clock phase
    logic masterFault; // select low on a master
    logic slaveFault;  // select high during slave transfer
    logic modeFault_r; // sticky mode fault flag
    sms_pkg::sms_state_t state_r;

    assign enEff = moduleEnable && !faultOff_r;
    assign master = enEff && masterSelect;
    assign clock_phase_sel = clockPhaseSel;
    assign masterFault = master && modeFaultEnable && !ssF;
    assign slaveFault = enEff && !masterSelect && modeFaultEnable
                        && ssF && (state_r == sms_pkg::ST_RUN);

    // master fault acts like writing zero to the enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultOff_r <= 1'b0;
        end else if (masterFault) begin
            faultOff_r <= 1'b1;
        end else if (!moduleEnable) begin
            faultOff_r <= 1'b0;
        end
    end

    // sticky fault flag, set wins over clear, kept while disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modeFault_r <= 1'b0;
        end else if (masterFault || slaveFault) begin
            modeFault_r <= 1'b1;
        end else if (faultClear) begin
            modeFault_r <= 1'b0;
        end
    end

    // ---- bit clock divider ----
    logic [6:0] divCnt_r;  // free-running half-bit counter
    logic [6:0] halfCnt;   // half bit for current rate
    logic       tick;      // one-cycle half-bit enable

    assign halfCnt = sms_pkg::sms_half_bit({rateSelectHi, rateSelectLo});
    assign tick = master && (divCnt_r == 7'(halfCnt - 7'h01));

    // runs only for an enabled master, free of any transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_r <= sms_pkg::DIV_RST;
        end else if (!master) begin
            divCnt_r <= sms_pkg::DIV_RST;
        end else if (tick) begin
            divCnt_r <= sms_pkg::DIV_RST;
        end else begin
            divCnt_r <= 7'(divCnt_r + 7'h01);
        end
    end

    // ---- transmit buffer ----
    sms_stream_if #(.W(8)) txIn ();
    sms_stream_if #(.W(8)) txOut ();
    logic popFire;   // buffer byte moves into the shifter

    assign txIn.valid  = txWrite;
    assign txIn.data   = txData;
    assign txEmptyFlag = txIn.ready;

    sms_fifo #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_txbuf (
        .clk   (clk),
        .rst   (rst),
        .flush (!enEff),
        .inS   (txIn),
        .outS  (txOut)
    );

    // ---- sequencer ----
    logic [3:0] edgeCnt_r;  // sck edge index within the byte
    logic [7:0] shreg_r;    // shift register
    logic       sample_r;   // last captured bit
    logic       slvSel;     // enabled slave, selected
    logic       slvStart;   // slave transfer begins now
    logic       slvAbort;   // select lost mid-transfer
    logic       edgeEv;     // an sck edge is processed
    logic       sampleEdge; // this edge captures
    logic       firstDrive; // phase-one opening edge
    logic       inBit;      // incoming serial bit
    logic       done;       // byte complete
    logic [7:0] newByte;    // byte completed at last edge

    assign slvSel = enEff && !masterSelect && !ssF;
    // phase one: first sck edge leaving idle; phase zero: select fall
    assign slvStart = slvSel && (state_r == sms_pkg::ST_IDLE)
                      && (clock_phase_sel ? (sckEdge && (sckF != clockPolaritySel))
                               : ssFall);
    assign slvAbort = enEff && !masterSelect && ssF
                      && (state_r == sms_pkg::ST_RUN);
    // loads happen only while idle, never during a slave transfer
    assign txOut.ready = enEff && (state_r == sms_pkg::ST_IDLE)
                         && !slvStart;
    assign popFire = txOut.valid && txOut.ready;

    always_comb begin
        if (master) begin
            edgeEv = (state_r == sms_pkg::ST_RUN) && tick;
        end else if (state_r == sms_pkg::ST_RUN) begin
            edgeEv = slvSel && sckEdge;
        end else begin
            edgeEv = slvStart && clock_phase_sel;
        end
    end

    assign sampleEdge = edgeCnt_r[0] == clock_phase_sel;
    assign firstDrive = clock_phase_sel && (edgeCnt_r == sms_pkg::EDGE_RST);
    assign inBit = master ? misoF : mosiF;
    assign newByte = {shreg_r[6:0], clock_phase_sel ? inBit : sample_r};
    assign done = edgeEv && (edgeCnt_r == sms_pkg::LAST_EDGE);

    // state and edge counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r   <= sms_pkg::ST_IDLE;
            edgeCnt_r <= sms_pkg::EDGE_RST;
        end else if (!enEff || slvAbort) begin
            state_r   <= sms_pkg::ST_IDLE;
            edgeCnt_r <= sms_pkg::EDGE_RST;
        end else begin
            unique case (state_r)
                sms_pkg::ST_IDLE: begin
                    if (master && popFire) begin
                        // phase zero holds sck for half a bit
                        state_r <= clock_phase_sel ? sms_pkg::ST_RUN
                                        : sms_pkg::ST_LEAD;
                    end else if (slvStart) begin
                        state_r <= sms_pkg::ST_RUN;
                        edgeCnt_r <= clock_phase_sel ? 4'h1 : sms_pkg::EDGE_RST;
                    end
                end
                sms_pkg::ST_LEAD: begin
                    if (tick) state_r <= sms_pkg::ST_RUN;
                end
                sms_pkg::ST_RUN: begin
                    if (done) begin
                        // next queued byte loads the following cycle
                        state_r   <= sms_pkg::ST_IDLE;
                        edgeCnt_r <= sms_pkg::EDGE_RST;
                    end else if (edgeEv) begin
                        edgeCnt_r <= 4'(edgeCnt_r + 4'h1);
                    end
                end
            endcase
        end
    end

    // shift register: load, shift, close out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shreg_r <= sms_pkg::SHIFT_RST;
        end else if (!enEff) begin
            shreg_r <= sms_pkg::SHIFT_RST;
        end else if (popFire) begin
            shreg_r <= txOut.data;
        end else if (done) begin
            // received byte kept and sent next if nothing new is queued
            shreg_r <= newByte;
        end else if (edgeEv && !sampleEdge && !firstDrive) begin
            shreg_r <= {shreg_r[6:0], sample_r};
        end
    end

    // capture on the sampling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_r <= 1'b0;
        end else if (edgeEv && sampleEdge) begin
            sample_r <= inBit;
        end
    end

    // ---- master serial clock ----
    logic sckAct_r;  // clock at active level

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sckAct_r <= 1'b0;
        end else if (!master || state_r != sms_pkg::ST_RUN) begin
            sckAct_r <= 1'b0;
        end else if (edgeEv) begin
            sckAct_r <= !sckAct_r;
        end
    end

    // ---- receive register and flags ----
    logic [7:0] rxData_r;   // last accepted byte
    logic       rxFull_r;   // unread byte present
    logic       overrun_r;  // byte lost
    logic       overflow;   // completion onto unread byte

    assign overflow = done && rxFull_r && !rxRead;

    // data and full flag move together; new byte wins over read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxData_r <= sms_pkg::RXDATA_RST;
            rxFull_r <= 1'b0;
        end else if (done && !overflow) begin
            rxData_r <= newByte;
            rxFull_r <= 1'b1;
        end else if (rxRead) begin
            rxFull_r <= 1'b0;
        end
    end

    // overflow keeps the unread byte; set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overrun_r <= 1'b0;
        end else if (overflow) begin
            overrun_r <= 1'b1;
        end else if (overrunClear) begin
            overrun_r <= 1'b0;
        end
    end

    // ---- outputs ----
    assign rxData        = rxData_r;
    assign rxFullFlag    = rxFull_r;
    assign overrunFlag   = overrun_r;
    assign modeFaultFlag = modeFault_r;
    assign moduleActive  = enEff;
    // pins released to general I/O while disabled
    assign serialClockPinOut = sckAct_r ^ clockPolaritySel;
    assign serialClockPinOe  = master;
    assign mosiOut = shreg_r[7];
    assign mosiOe  = master;
    assign misoOut = shreg_r[7];
    assign misoOe  = slvSel;

    // ---- checks ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_miso_sel;
        misoOe |-> !ssF && !masterSelect && enEff;
    endproperty
    a_miso_sel: assert property (p_miso_sel)
        else $error("miso driven while not selected");

    property p_disable_clear;
        !moduleEnable |-> (!mosiOe && !misoOe && !serialClockPinOe)
            ##1 (state_r == sms_pkg::ST_IDLE
            && shreg_r == sms_pkg::SHIFT_RST && txEmptyFlag);
    endproperty
    a_disable_clear: assert property (p_disable_clear)
        else $error("disable did not reset the engine");

    property p_empty_back;
        popFire && txEmptyFlag && !txWrite |=> txEmptyFlag [*2];
    endproperty
    a_empty_back: assert property (p_empty_back)
        else $error("empty flag not back after load");

    property p_slave_noload;
        (state_r == sms_pkg::ST_RUN && !masterSelect) |-> !popFire;
    endproperty
    a_slave_noload: assert property (p_slave_noload)
        else $error("buffer loaded during slave transfer");

    property p_start_delay;
        (popFire && master && halfCnt == 7'h01) |-> ##[1:2] edgeEv
            || state_r == sms_pkg::ST_RUN;
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("master start too late");

    property p_rx_load;
        (done && !rxFull_r) |=> rxFull_r && rxData_r == $past(newByte);
    endproperty
    a_rx_load: assert property (p_rx_load)
        else $error("received byte not stored with full flag");

    property p_overflow;
        overflow |=> overrun_r && $stable(rxData_r) && rxFull_r;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not keep unread byte");

    property p_fault_off;
        (masterFault && moduleEnable) |=> !enEff [*2] or !moduleEnable;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("master mode fault left module enabled");

    property p_div_idle;
        !master |-> !tick ##1 divCnt_r == sms_pkg::DIV_RST;
    endproperty
    a_div_idle: assert property (p_div_idle)
        else $error("bit clock ran while not an enabled master");
endmodule : sms_core

// File: rtl/sms_fifo.sv
/*
 * sms_fifo: small flip-flop FIFO, the queued transmit buffer.
 * Assumes one clock; flush empties it in one cycle.
 */
`timescale 1ns/100ps
module sms_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // fill and drain sides
    sms_stream_if.snk inS,
    sms_stream_if.src outS
);
    localparam int unsigned IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("sms_fifo: DEPTH must be >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];  // storage
    logic [IW-1:0]    rdIdx_r;        // oldest entry
    logic [IW-1:0]    wrIdx_r;        // next free entry
    logic [CW-1:0]    count_r;        // entries held
    logic             push;
    logic             pop;

    // honest full and empty
    assign inS.ready  = (count_r != CW'(DEPTH));
    assign outS.valid = (count_r != '0);
    assign outS.data  = mem_r[rdIdx_r];
    assign push       = inS.valid && inS.ready;
    assign pop        = outS.valid && outS.ready;

    // index wrap
    function automatic logic [IW-1:0] nextIdx(input logic [IW-1:0] i);
        nextIdx = (i == IW'(DEPTH - 1)) ? '0 : IW'(i + 1'b1);
    endfunction : nextIdx

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wrIdx_r] <= inS.data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdIdx_r <= '0;
            wrIdx_r <= '0;
            count_r <= '0;
        end else if (flush) begin
            rdIdx_r <= '0;
            wrIdx_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wrIdx_r <= nextIdx(wrIdx_r);
            if (pop)  rdIdx_r <= nextIdx(rdIdx_r);
            if (push && !pop)      count_r <= CW'(count_r + 1'b1);
            else if (pop && !push) count_r <= CW'(count_r - 1'b1);
        end
    end
endmodule : sms_fifo

// File: rtl/sms_pkg.sv
/*
 * sms_pkg: shared constants and types of the serial shift core.
 * Assumes a single 10 MHz bus clock; nothing else is required.
 */
package sms_pkg;
    // byte and buffer shape
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned BUF_DEPTH  = 2;
    // edge counter: 16 sck edges per byte
    localparam logic [3:0]  LAST_EDGE  = 4'hf;
    localparam logic [3:0]  EDGE_RST   = 4'h0;
    // reset values
    localparam logic [7:0]  SHIFT_RST  = 8'h00;
    localparam logic [7:0]  RXDATA_RST = 8'h00;
    localparam logic [6:0]  DIV_RST    = 7'h00;
    // pin order {sck, mosi, miso, select_n}; select idles high
    localparam logic [3:0]  PIN_RST    = 4'h1;
    // bus cycles per bit for rate codes 0..3
    localparam int unsigned BIT_CYC_0  = 2;
    localparam int unsigned BIT_CYC_1  = 8;
    localparam int unsigned BIT_CYC_2  = 32;
    localparam int unsigned BIT_CYC_3  = 128;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LEAD,
        ST_RUN
    } sms_state_t;

    // half a bit time in bus cycles for a rate code
    function automatic logic [6:0] sms_half_bit(input logic [1:0] rate);
        unique case (rate)
            2'h0: sms_half_bit = 7'(BIT_CYC_0 / 2);
            2'h1: sms_half_bit = 7'(BIT_CYC_1 / 2);
            2'h2: sms_half_bit = 7'(BIT_CYC_2 / 2);
            2'h3: sms_half_bit = 7'(BIT_CYC_3 / 2);
        endcase
    endfunction : sms_half_bit
endpackage : sms_pkg

// File: rtl/sms_stream_if.sv
/*
 * sms_stream_if: valid/ready byte stream between core and buffer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
interface sms_stream_if #(parameter int unsigned W = 8);
    logic         valid;    // word offered
    logic         ready;    // word accepted when both high
    logic [W-1:0] data;     // offered word
    // producer end
    modport src (output valid, output data, input ready);
    // consumer end
    modport snk (input valid, input data, output ready);
endinterface : sms_stream_if

// File: tb/sms_far_master.sv
/*
 * sms_far_master: far-end master model that drives the core's slave side.
 * Assumes phase one and a serial clock that idles low, 800 ns period.
 */
`timescale 1ns/100ps
module sms_far_master (
    // link lines toward the core
    output logic     sckLine,
    output logic     mosiLine,
    output logic     selN,
    // core's data line and its drive enable
    input wire logic misoLine,
    input wire logic misoOe
);
    // clock stands still between frames, no slave selected
    initial begin
        sckLine = 1'b0;
        mosiLine = 1'b0;
        selN = 1'b1;
    end

    // one byte, msb first, data out on each bit's first edge
    task automatic xfer(input logic [7:0] tx, input logic keep,
                        output logic [7:0] rx);
        selN = 1'b0;
        #800;
        for (int i = 7; i >= 0; i--) begin
            sckLine = 1'b1;
            mosiLine = tx[i];
            #400;
            sckLine = 1'b0;
            #300; // margin for the core's pin filter
            rx[i] = misoOe ? misoLine : 1'bx;
            #100;
        end
        mosiLine = ~tx[0]; // released line shows no stale bit
        if (!keep) selN = 1'b1;
        #800;
    endtask : xfer
endmodule : sms_far_master

// File: tb/tb_top.sv
/*
 * tb_top: self-checking bench of the serial shift core.
 * Assumes the far master model; mosi loops back inverted to miso.
 */
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, rst = 1, moduleEnable = 0, masterSelect = 0;
    logic clockPhaseSel = 1, clockPolaritySel = 0, modeFaultEnable = 0;
    logic rateSelectHi = 0, rateSelectLo = 0, txWrite = 0, rxRead = 0;
    logic overrunClear = 0, faultClear = 0, holdRd = 0;
    logic [7:0] txData = 8'h00, a, b, c, got, rxData;
    logic txEmptyFlag, rxFullFlag, overrunFlag, modeFaultFlag, moduleActive;
    logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, sckLine, mosiLine;
    logic selN;
    logic [7:0] expQ[$]; // expected received bytes
    int n_fail = 0, tests_run = 0, cyc = 0, nRd = 0, n, hb, lim;
    int bitCyc[4] = '{sms_pkg::BIT_CYC_0, sms_pkg::BIT_CYC_1,
                      sms_pkg::BIT_CYC_2, sms_pkg::BIT_CYC_3};

    sms_core #(.BUF_DEPTH(2)) dut_u (.clk(clk), .rst(rst),
        .moduleEnable(moduleEnable), .masterSelect(masterSelect),
        .clockPhaseSel(clockPhaseSel), .clockPolaritySel(clockPolaritySel),
        .modeFaultEnable(modeFaultEnable), .rateSelectHi(rateSelectHi),
        .rateSelectLo(rateSelectLo), .txWrite(txWrite), .txData(txData),
        .txEmptyFlag(txEmptyFlag), .rxRead(rxRead),
        .overrunClear(overrunClear), .faultClear(faultClear),
        .rxData(rxData), .rxFullFlag(rxFullFlag), .overrunFlag(overrunFlag),
        .modeFaultFlag(modeFaultFlag), .moduleActive(moduleActive),
        .serialClockPinIn(sckLine), .serialClockPinOut(sckOut),
        .serialClockPinOe(sckOe), .mosiIn(mosiLine), .mosiOut(mosiOut),
        .mosiOe(mosiOe), .misoIn(~mosiOut), .misoOut(misoOut),
        .misoOe(misoOe), .slaveSelN(selN));
    sms_far_master far_u (.sckLine(sckLine), .mosiLine(mosiLine),
        .selN(selN), .misoLine(misoOut), .misoOe(misoOe));

    always #50 clk = ~clk;

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task summarize;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // reconfigure while disabled, then enable
    task automatic setup(input logic ms, ph, pol, input logic [1:0] r);
        @(negedge clk) moduleEnable = 1'b0;
        @(negedge clk) {masterSelect, clockPhaseSel, clockPolaritySel} =
            {ms, ph, pol};
        {rateSelectHi, rateSelectLo} = r;
        @(negedge clk) moduleEnable = 1'b1;
        repeat (2) @(negedge clk);
    endtask : setup

    task automatic waitRd(input int t);
        n = 0;
        while (nRd < t && n < 4000) begin
            @(negedge clk);
            n++;
        end
        chk(nRd >= t, "rx count");
    endtask : waitRd

    // result watcher: compare each received byte that has an expected value queued, then read it
    always @(negedge clk) begin
        if (rxFullFlag === 1'b1 && !rxRead && !holdRd) begin
            nRd++;
            if (expQ.size() > 0) chk(rxData === expQ.pop_front(), "rx");
        end
        rxRead <= rxFullFlag === 1'b1 && !rxRead && !holdRd;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end

    initial begin
        a = 8'($urandom(32'h0bc416cd));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(txEmptyFlag === 1 && {rxFullFlag, overrunFlag} === 2'b00, "rst");
        chk(modeFaultFlag === 0 && rxData === sms_pkg::RXDATA_RST, "rst");
        chk({sckOe, mosiOe, misoOe} === 3'b000, "pins off");
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            setup(1'b1, k[0], 1'($urandom), k[2:1]);
            hb = bitCyc[k / 2] / 2;
            chk(sckOut === clockPolaritySel && sckOe === 1, "idle");
            txWrite = 1'b1;
            txData = a;
            n = 0;
            while (sckOut === clockPolaritySel && n < 300) begin
                @(negedge clk);
                txWrite = 1'b0;
                n++;
            end
            lim = bitCyc[k / 2] + (k[0] ? 0 : hb) + 3;
            chk(n <= lim && (k[0] || n > hb), "delay");
            chk(txEmptyFlag === 1'b1, "tx empty");
            @(negedge clk) txWrite = 1'b1;
            txData = b;
            @(negedge clk) txWrite = 1'b0;
            if (k >= 4) begin
                expQ.push_back(~a);
                expQ.push_back(~b);
            end
            waitRd(nRd + 2);
        end
        $display("test master done");
        setup(1'b1, 1'b1, 1'b0, 2'h2);
        modeFaultEnable = 1'b1;
        far_u.selN = 1'b0;
        repeat (10) @(negedge clk);
        chk(modeFaultFlag === 1 && moduleActive === 0, "fault");
        chk(sckOe === 1'b0 && txEmptyFlag === 1'b1, "fault off");
        far_u.selN = 1'b1;
        modeFaultEnable = 1'b0;
        faultClear = 1'b1;
        @(negedge clk) faultClear = 1'b0;
        chk(modeFaultFlag === 1'b0, "fault clear");
        $display("test fault done");
        setup(1'b0, 1'b1, 1'b0, 2'h0);
        chk(misoOe === 1'b0, "miso off");
        c = 8'($urandom);
        txWrite = 1'b1;
        txData = a;
        @(negedge clk) txWrite = 1'b0;
        expQ.push_back(c);
        fork
            far_u.xfer(c, 1'b1, got);
            begin
                repeat (30) @(negedge clk);
                txWrite = 1'b1;
                txData = b;
                @(negedge clk) txWrite = 1'b0;
            end
        join
        chk(got === a, "slave first");
        expQ.push_back(~c);
        far_u.xfer(~c, 1'b1, got);
        chk(got === b, "slave queued");
        expQ.push_back(c ^ 8'h3c);
        far_u.xfer(c ^ 8'h3c, 1'b0, got);
        chk(got === ~c, "slave resend");
        holdRd = 1'b1;
        far_u.xfer(a, 1'b1, got);
        far_u.xfer(b, 1'b0, got);
        expQ.push_back(a);
        chk(overrunFlag === 1'b1 && rxData === a, "overrun");
        moduleEnable = 1'b0;
        repeat (2) @(negedge clk);
        chk(txEmptyFlag === 1 && {mosiOe, misoOe} === 2'b00, "off");
        chk(overrunFlag === 1'b1 && rxFullFlag === 1'b1, "kept");
        holdRd = 1'b0;
        waitRd(nRd + 1);
        overrunClear = 1'b1;
        @(negedge clk) overrunClear = 1'b0;
        chk(overrunFlag === 1'b0, "overrun clear");
        $display("test slave done");
        summarize();
    end
endmodule : tb_top
